/* hw/iwd_core.v */
// instruction word decoder with read-modify-write sequencer and axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "iwd_map.vh"
module iwd_core (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire debug_enable_pin_n_i,
  output reg debug_en_o,
  output reg [6:0] file_addr_o,
  output reg file_rd_o,
  input wire [7:0] file_rdata_i,
  output reg file_wr_o,
  output reg [7:0] file_wdata_o,
  output reg [5:0] alu_sel_o,
  output reg [7:0] alu_opnd_o,
  output wire [7:0] alu_w_o,
  input wire [7:0] alu_res_i,
  output reg icyc_tick_o,
  output reg pc_load_o,
  output reg [10:0] pc_target_o,
  output reg skip_o,
  output wire busy_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_NOP = 2'h2;

  reg [1:0] state_r;
  reg [1:0] q_r;
  reg [13:0] instr_r;
  reg [13:0] ir_r;
  reg [7:0] wreg_r;
  reg [7:0] opnd_r;
  reg [7:0] res_r;
  reg two_r;
  reg skip_r;
  reg pcchg_r;
  reg dhit_r;
  reg dsync_r;
  reg [31:0] cyc_r;
  reg go_r;
  reg clr_r;

  wire [1:0] cat;
  wire [6:0] faddr;
  wire [2:0] bsel;
  wire [7:0] k8;
  wire [10:0] k11;
  wire uses_file;
  wire wr_f;
  wire wr_w;
  wire [1:0] skip_kind;
  wire pc_chg;
  wire bit_val;

  iwd_decode u_dec (
    .instr_i(ir_r),
    .cat_o(cat),
    .faddr_o(faddr),
    .bsel_o(bsel),
    .k8_o(k8),
    .k11_o(k11),
    .dest_f_o(),
    .uses_file_o(uses_file),
    .wr_f_o(wr_f),
    .wr_w_o(wr_w),
    .skip_o(skip_kind),
    .pc_chg_o(pc_chg),
    .bit_val_o(bit_val)
  );

  // decoded view of the staged word, for the field and status registers
  wire [1:0] v_cat;
  wire [6:0] v_faddr;
  wire [2:0] v_bsel;
  wire [10:0] v_k11;
  wire v_dest;

  iwd_decode u_view (
    .instr_i(instr_r),
    .cat_o(v_cat),
    .faddr_o(v_faddr),
    .bsel_o(v_bsel),
    .k8_o(),
    .k11_o(v_k11),
    .dest_f_o(v_dest),
    .uses_file_o(),
    .wr_f_o(),
    .wr_w_o(),
    .skip_o(),
    .pc_chg_o(),
    .bit_val_o()
  );

  assign alu_w_o = wreg_r;
  assign busy_o = (state_r != ST_IDLE);

  // bit instructions modify in place; byte and literal results come from the alu
  wire [7:0] bit_mask = 8'h01 << bsel;
  wire bit_now = |(opnd_r & bit_mask);
  wire [7:0] bit_res = bit_val ? (opnd_r | bit_mask) : (opnd_r & ~bit_mask);
  wire [7:0] mod_res = (cat == `IWD_CAT_BIT) ? bit_res : alu_res_i;
  reg skip_hit;

  always @* begin
    case (skip_kind)
      2'h1: skip_hit = (alu_res_i == 8'h00);
      2'h2: skip_hit = ~bit_now;
      2'h3: skip_hit = bit_now;
      default: skip_hit = 1'b0;
    endcase
  end

  // axi4-lite write path: address and data caught in either order
  reg aw_full_r;
  reg w_full_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire do_wr = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready = ~w_full_r;

  function [31:0] lanes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      lanes = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lanes[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  wire wr_ctrl = do_wr & (aw_addr_r == `IWD_OFF_CTRL);
  wire wr_instr = do_wr & (aw_addr_r == `IWD_OFF_INSTR);
  wire wr_wreg = do_wr & (aw_addr_r == `IWD_OFF_WREG);
  wire [31:0] ctrl_v = lanes(32'h0, w_data_r, w_strb_r);
  wire [31:0] instr_v = lanes({18'h0, instr_r}, w_data_r, w_strb_r);
  wire [31:0] wreg_v = lanes({24'h0, wreg_r}, w_data_r, w_strb_r);
  reg wr_ok;

  always @* begin
    if (aw_addr_r == `IWD_OFF_CTRL) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `IWD_OFF_INSTR) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `IWD_OFF_WREG) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `IWD_OFF_STAT || aw_addr_r == `IWD_OFF_FLD) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `IWD_OFF_CYC) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IWD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `IWD_RESP_OKAY : `IWD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read path, one cycle after the address is taken
  wire [31:0] stat_v = {23'h0, pcchg_r, skip_r, dhit_r, debug_en_o, v_dest, v_cat, two_r, busy_o};
  wire [31:0] fld_v = {5'h0, v_k11, 5'h0, v_bsel, 1'b0, v_faddr};
  wire [7:0] ar_a = {s_axi_araddr[7:2], 2'b00};
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `IWD_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `IWD_RESP_OKAY;
      if (ar_a == `IWD_OFF_CTRL) begin
        s_axi_rdata <= 32'h0;
      end else if (ar_a == `IWD_OFF_INSTR) begin
        s_axi_rdata <= {18'h0, instr_r};
      end else if (ar_a == `IWD_OFF_WREG) begin
        s_axi_rdata <= {24'h0, wreg_r};
      end else if (ar_a == `IWD_OFF_STAT) begin
        s_axi_rdata <= stat_v;
      end else if (ar_a == `IWD_OFF_FLD) begin
        s_axi_rdata <= fld_v;
      end else if (ar_a == `IWD_OFF_CYC) begin
        s_axi_rdata <= cyc_r;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `IWD_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // staged word and command pulses; go while busy is dropped
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      instr_r <= `IWD_INSTR_RST;
      go_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      if (wr_instr) begin
        instr_r <= instr_v[13:0];
      end
      go_r <= wr_ctrl & ctrl_v[`IWD_CTRL_GO];
      clr_r <= wr_ctrl & ctrl_v[`IWD_CTRL_CLR];
    end
  end

  // debug enable pin is synchronised through two registers, dsync_r then debug_en_o
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dsync_r <= 1'b0;
      debug_en_o <= 1'b0;
    end else begin
      dsync_r <= ~debug_enable_pin_n_i;
      debug_en_o <= dsync_r;
    end
  end

  // sequencer: q1 decode, q2 read file, q3 modify, q4 store
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      q_r <= 2'h0;
      ir_r <= `IWD_INSTR_RST;
      wreg_r <= `IWD_WREG_RST;
      opnd_r <= 8'h00;
      res_r <= 8'h00;
      two_r <= 1'b0;
      skip_r <= 1'b0;
      pcchg_r <= 1'b0;
      dhit_r <= 1'b0;
      cyc_r <= 32'h0;
      file_addr_o <= 7'h00;
      file_rd_o <= 1'b0;
      file_wr_o <= 1'b0;
      file_wdata_o <= 8'h00;
      alu_sel_o <= 6'h00;
      alu_opnd_o <= 8'h00;
      icyc_tick_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_target_o <= 11'h000;
      skip_o <= 1'b0;
    end else begin
      file_rd_o <= 1'b0;
      file_wr_o <= 1'b0;
      icyc_tick_o <= 1'b0;
      pc_load_o <= 1'b0;
      skip_o <= 1'b0;
      if (wr_wreg) begin
        wreg_r <= wreg_v[7:0];
      end
      if (clr_r) begin
        cyc_r <= 32'h0;
      end
      case (state_r)
        ST_IDLE: begin
          q_r <= 2'h0;
          if (go_r) begin
            ir_r <= instr_r;
            state_r <= ST_EXEC;
            two_r <= 1'b0;
            skip_r <= 1'b0;
            pcchg_r <= 1'b0;
          end
        end
        ST_EXEC: begin
          q_r <= q_r + 2'h1;
          if (q_r == 2'h0) begin
            file_addr_o <= faddr;
            alu_sel_o <= ir_r[13:8];
            file_rd_o <= uses_file;
          end
          if (q_r == 2'h1) begin
            opnd_r <= uses_file ? file_rdata_i : k8;
            alu_opnd_o <= uses_file ? file_rdata_i : k8;
          end
          if (q_r == 2'h2) begin
            res_r <= mod_res;
            skip_r <= skip_hit;
            pcchg_r <= pc_chg;
          end
          if (q_r == `IWD_QPHASES) begin
            icyc_tick_o <= 1'b1;
            cyc_r <= cyc_r + 32'h1;
            if (wr_f) begin
              file_wr_o <= 1'b1;
              file_wdata_o <= res_r;
            end
            if (wr_w) begin
              wreg_r <= res_r;
            end
            if (pcchg_r) begin
              pc_load_o <= 1'b1;
              pc_target_o <= k11;
            end
            skip_o <= skip_r;
            two_r <= skip_r | pcchg_r;
            state_r <= (skip_r | pcchg_r) ? ST_NOP : ST_IDLE;
          end
        end
        ST_NOP: begin
          // second cycle does nothing but take its four periods
          q_r <= q_r + 2'h1;
          if (q_r == `IWD_QPHASES) begin
            icyc_tick_o <= 1'b1;
            cyc_r <= cyc_r + 32'h1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // flags a jump into the debugger's reserved range; set beats clear
      if (state_r == ST_EXEC && q_r == 2'h2 && debug_en_o && pc_chg
          && ir_r[13:12] == 2'b10 && k11 >= `IWD_DBG_LO) begin
        dhit_r <= 1'b1;
      end else if (clr_r) begin
        dhit_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/iwd_map.vh */
// register map, field positions and timing counts of the instruction decoder
`ifndef IWD_MAP_VH
`define IWD_MAP_VH
`define IWD_OFF_CTRL 8'h00
`define IWD_OFF_INSTR 8'h04
`define IWD_OFF_WREG 8'h08
`define IWD_OFF_STAT 8'h0c
`define IWD_OFF_FLD 8'h10
`define IWD_OFF_CYC 8'h14
`define IWD_CTRL_GO 0
`define IWD_CTRL_CLR 1
`define IWD_INSTR_W 14
`define IWD_INSTR_RST 14'h0000
`define IWD_WREG_RST 8'h00
`define IWD_ST_BUSY 0
`define IWD_ST_TWO 1
`define IWD_ST_CAT 2
`define IWD_ST_DEST 4
`define IWD_ST_DBG 5
`define IWD_ST_DHIT 6
`define IWD_ST_SKIP 7
`define IWD_ST_PCCHG 8
`define IWD_FLD_F 0
`define IWD_FLD_B 8
`define IWD_FLD_K 16
`define IWD_QPHASES 2'h3
`define IWD_DBG_LO 11'h700
`define IWD_CAT_BYTE 2'h0
`define IWD_CAT_BIT 2'h1
`define IWD_CAT_LIT 2'h2
`define IWD_RESP_OKAY 2'h0
`define IWD_RESP_SLVERR 2'h2
`endif

/* hw/iwd_decode.v */
// combinational split of a 14-bit instruction word into category and fields
`timescale 1ns/10ps
`default_nettype none
`include "iwd_map.vh"
module iwd_decode (
  input wire [13:0] instr_i,
  output reg [1:0] cat_o,
  output wire [6:0] faddr_o,
  output wire [2:0] bsel_o,
  output wire [7:0] k8_o,
  output wire [10:0] k11_o,
  output wire dest_f_o,
  output reg uses_file_o,
  output reg wr_f_o,
  output reg wr_w_o,
  output reg [1:0] skip_o,
  output reg pc_chg_o,
  output reg bit_val_o
);
  assign faddr_o = instr_i[6:0];
  assign bsel_o = instr_i[9:7];
  assign k8_o = instr_i[7:0];
  assign k11_o = instr_i[10:0];
  assign dest_f_o = instr_i[7];
  // skip kinds: 0 none, 1 result zero, 2 bit clear, 3 bit set
  always @* begin
    cat_o = `IWD_CAT_LIT;
    uses_file_o = 1'b0;
    wr_f_o = 1'b0;
    wr_w_o = 1'b0;
    skip_o = 2'h0;
    pc_chg_o = 1'b0;
    bit_val_o = 1'b0;
    casez (instr_i[13:12])
      2'b00: begin
        if (instr_i[11:7] == 5'h00) begin
          // control words; bits 6..1 all compared for the pc change, only bit 0 don't care
          pc_chg_o = (instr_i[6:1] == 6'h04);
        end else if (instr_i[11:7] == 5'h02) begin
          cat_o = `IWD_CAT_BYTE;
          wr_w_o = 1'b1;
        end else begin
          cat_o = `IWD_CAT_BYTE;
          uses_file_o = 1'b1;
          wr_f_o = instr_i[7];
          wr_w_o = ~instr_i[7];
          if (instr_i[11:8] == 4'hb || instr_i[11:8] == 4'hf) begin
            skip_o = 2'h1;
          end
        end
      end
      2'b01: begin
        cat_o = `IWD_CAT_BIT;
        uses_file_o = 1'b1;
        if (instr_i[11]) begin
          skip_o = {1'b1, instr_i[10]};
        end else begin
          wr_f_o = 1'b1;
          bit_val_o = instr_i[10];
        end
      end
      2'b10: begin
        pc_chg_o = 1'b1;
      end
      default: begin
        wr_w_o = 1'b1;
        pc_chg_o = (instr_i[11:10] == 2'b01);
      end
    endcase
  end
endmodule
`default_nettype wire

/* testbench/iwd_core_props.sv */
// port-level checks for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
module iwd_core_props (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic debug_enable_pin_n_i,
  input wire logic debug_en_o,
  input wire logic file_rd_o,
  input wire logic file_wr_o,
  input wire logic icyc_tick_o,
  input wire logic pc_load_o,
  input wire logic skip_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_wr_on_tick: assert property (file_wr_o |-> icyc_tick_o)
    else $error("file write away from cycle end");
  chk_rd_then_tick: assert property (file_rd_o |-> ##[1:4] icyc_tick_o)
    else $error("file read not followed by cycle end");
  chk_tick_gap: assert property (icyc_tick_o |=> !icyc_tick_o [*3])
    else $error("instruction cycle shorter than four clocks");
  chk_pc_nop: assert property (pc_load_o |-> ##[1:5] icyc_tick_o)
    else $error("no second cycle after pc change");
  chk_skip_nop: assert property (skip_o |-> ##[1:5] icyc_tick_o)
    else $error("no second cycle after skip");
  chk_pulse_busy: assert property ((file_rd_o || file_wr_o || icyc_tick_o) |-> $past(busy_o))
    else $error("execution pulse while idle");
  chk_dbg_on: assert property (!debug_enable_pin_n_i [*4] |-> debug_en_o)
    else $error("debug not enabled with pin low");
  chk_dbg_off: assert property (debug_enable_pin_n_i [*4] |-> !debug_en_o)
    else $error("debug enabled with pin high");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule
bind iwd_core iwd_core_props u_props (.clk_i, .resetn_i, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .debug_enable_pin_n_i, .debug_en_o, .file_rd_o, .file_wr_o, .icyc_tick_o, .pc_load_o,
  .skip_o, .busy_o);
`default_nettype wire

/* testbench/iwd_core_bench.sv */
// register-level bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module iwd_core_bench;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, debug_enable_pin_n_i = 1'h1;
  // fixed operands: bit 2 set and bit 7 clear make the skip and set cases visible
  logic [7:0] file_rdata_i = 8'h3c, alu_res_i = 8'h5a;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic debug_en_o, file_rd_o, file_wr_o, icyc_tick_o, pc_load_o, skip_o, busy_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_d, st;
  logic [1:0] rd_r, wr_r;
  logic [6:0] file_addr_o, wa;
  logic [7:0] file_wdata_o, alu_opnd_o, alu_w_o, wd;
  logic [5:0] alu_sel_o;
  logic [10:0] pc_target_o;
  int cnt[6];
  int failures = 0;
  int check_count = 0;
  always #2.5 clk_i = ~clk_i;
  iwd_core DUT (.clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .debug_enable_pin_n_i, .debug_en_o, .file_addr_o, .file_rd_o, .file_rdata_i,
    .file_wr_o, .file_wdata_o, .alu_sel_o, .alu_opnd_o, .alu_w_o, .alu_res_i, .icyc_tick_o,
    .pc_load_o, .pc_target_o, .skip_o, .busy_o);
  // pulses are counted per instruction; the last file write is kept for inspection
  always @(posedge clk_i) begin
    cnt[0] += int'(file_rd_o);
    cnt[1] += int'(file_wr_o);
    cnt[2] += int'(icyc_tick_o);
    cnt[3] += int'(skip_o);
    cnt[4] += int'(pc_load_o);
    cnt[5] += int'(busy_o);
    if (file_wr_o) begin
      wd = file_wdata_o;
      wa = file_addr_o;
    end
  end
  task complete_run;
    begin
      if (failures == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // handshakes judged at the falling edge, where nothing is changing
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
        @(negedge clk_i);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = s_axi_bvalid && s_axi_bready;
        if (tb) wr_r = s_axi_bresp;
        @(posedge clk_i);
        if (ta) s_axi_awvalid <= 1'h0;
        if (tw) s_axi_wvalid <= 1'h0;
      end while (!tb);
    end
  endtask
  task axi_rd(input logic [7:0] a);
    logic ta, tr;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
        @(negedge clk_i);
        ta = s_axi_arvalid && s_axi_arready;
        tr = s_axi_rvalid && s_axi_rready;
        if (tr) rd_d = s_axi_rdata;
        if (tr) rd_r = s_axi_rresp;
        @(posedge clk_i);
        if (ta) s_axi_arvalid <= 1'h0;
      end while (!tr);
    end
  endtask
  // e: file reads, file writes, cycles, skips, pc changes
  task run(input logic [13:0] ins, input logic [1:0] cat, input int e[5]);
    int n;
    begin
      axi_wr(8'h04, {18'h0, ins});
      cnt = '{default: 0};
      axi_wr(8'h00, 32'h1);
      n = 0;
      while ((cnt[5] == 0 || busy_o !== 1'h0) && n < 60) begin
        @(negedge clk_i);
        n++;
      end
      // second edge lets the pulse counter settle before it is read
      repeat (2) @(posedge clk_i);
      for (int i = 0; i < 5; i++) `CHK(cnt[i], e[i])
      `CHK(cnt[5], 4 * e[2])
      `CHK(alu_sel_o, ins[13:8])
      axi_rd(8'h0c);
      st = rd_d;
      `CHK(st[3:2], cat)
      `CHK(st[1], e[2] == 2)
      `CHK(st[7], e[3] == 1)
      `CHK(st[8], e[4] == 1)
    end
  endtask
  initial begin
    #20000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    axi_rd(8'h04);
    `CHK(rd_d, 32'h0)
    axi_rd(8'h18);
    `CHK(rd_r, 2'h2)
    axi_wr(8'h08, 32'h11);
    `CHK(wr_r, 2'h0)
    axi_rd(8'h08);
    `CHK(rd_d, 32'h11)
    run(14'h077f, 2'h0, '{1, 0, 1, 0, 0});
    `CHK(alu_w_o, 8'h5a)
    `CHK(st[4], 1'h0)
    `CHK(alu_opnd_o, 8'h3c)
    axi_rd(8'h10);
    `CHK(rd_d[6:0], 7'h7f)
    run(14'h0780, 2'h0, '{1, 1, 1, 0, 0});
    `CHK(wd, 8'h5a)
    `CHK(st[4], 1'h1)
    run(14'h01a5, 2'h0, '{1, 1, 1, 0, 0});
    `CHK(wa, 7'h25)
    run(14'h1790, 2'h1, '{1, 1, 1, 0, 0});
    `CHK(wd, 8'hbc)
    axi_rd(8'h10);
    `CHK(rd_d[10:8], 3'h7)
    run(14'h1d10, 2'h1, '{1, 0, 2, 1, 0});
    run(14'h1910, 2'h1, '{1, 0, 1, 0, 0});
    run(14'h30a5, 2'h2, '{0, 0, 1, 0, 0});
    `CHK(alu_opnd_o, 8'ha5)
    axi_rd(8'h10);
    `CHK(rd_d[23:16], 8'ha5)
    run(14'h33a5, 2'h2, '{0, 0, 1, 0, 0});
    axi_rd(8'h10);
    `CHK(rd_d[23:16], 8'ha5)
    debug_enable_pin_n_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    `CHK(debug_en_o, 1'h1)
    run(14'h0000, 2'h2, '{0, 0, 1, 0, 0});
    axi_wr(8'h00, 32'h2);
    run(14'h2eff, 2'h2, '{0, 0, 2, 0, 1});
    `CHK(st[6:5], 2'h1)
    run(14'h2f00, 2'h2, '{0, 0, 2, 0, 1});
    `CHK(pc_target_o, 11'h700)
    `CHK(st[6], 1'h1)
    debug_enable_pin_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    `CHK(debug_en_o, 1'h0)
    run(14'h0008, 2'h2, '{0, 0, 2, 0, 1});
    axi_rd(8'h14);
    `CHK(rd_d, 32'h6)
    complete_run;
  end
endmodule
`default_nettype wire
